/* File: logic/wtpe_cfg.svh */
// Constants for the wheel touch position engine.
`ifndef WTPE_CFG_SVH
`define WTPE_CFG_SVH
`define WTPE_ADDR_DEBOUNCE 8'h27
`define WTPE_ADDR_STUCK 8'h28
`define WTPE_ADDR_MARGIN 8'h29
`define WTPE_ADDR_SCALE_HI 8'h2B
`define WTPE_ADDR_SCALE_LO 8'h2C
`define WTPE_ADDR_FILTER 8'h2D
`define WTPE_ADDR_NEG 8'h2E
`define WTPE_ADDR_NEG_CNT 8'h2F
`define WTPE_ADDR_SPIN 8'h30
`define WTPE_ADDR_ANGLE 8'h31
`define WTPE_ADDR_LOC_HI 8'h20
`define WTPE_ADDR_LOC_LO 8'h21
`define WTPE_ADDR_STATUS 8'h22
`define WTPE_RST_DEBOUNCE 8'h00
`define WTPE_RST_STUCK 8'h00
`define WTPE_RST_MARGIN 8'h03
`define WTPE_RST_SCALE_HI 8'h01
`define WTPE_RST_SCALE_LO 8'h00
`define WTPE_RST_FILTER 8'h50
`define WTPE_RST_NEG 8'h50
`define WTPE_RST_NEG_CNT 8'h01
`define WTPE_RST_SPIN 8'h02
`define WTPE_RST_ANGLE 8'h00
`define WTPE_SENSORS 8
`define WTPE_LEVEL_SHIFT 2
`define WTPE_SCALE_SHIFT 5
`define WTPE_LIMIT_SHIFT 2
`define WTPE_SEGMENT_SHIFT 8
`define WTPE_PERCENT 100
`define WTPE_SECOND_NS 1000000000
`define WTPE_CLK_PERIOD_NS 4
`define WTPE_COMP_MIN_SENSORS 3
`endif

/* File: logic/wtpe_pkg.sv */
// Types for the wheel touch position engine.
`default_nettype none
package wtpe_pkg;
	typedef enum logic [2:0] {
		WTPE_RELEASED = 3'b001,
		WTPE_TOUCHED = 3'b010,
		WTPE_STUCK = 3'b100
	} wtpe_state_t;
endpackage : wtpe_pkg
`default_nettype wire

/* File: logic/wtpe_sensor_lane.sv */
// One sensor lane: clipped tick excess and level comparisons.
`timescale 1ns/1ps
`default_nettype none
`include "wtpe_cfg.svh"
module wtpe_sensor_lane (
	input wire logic signed [15:0] ticks,
	input wire logic signed [15:0] touchLevel,
	input wire logic [9:0] filterLevel,
	input wire logic [9:0] negLevel,
	output logic [16:0] clipped,
	output logic aboveFilter,
	output logic belowNeg
);
	wire logic signed [17:0] excess;
	assign excess = 18'(ticks) - 18'(touchLevel);
	// Sensors under their touch level contribute nothing. [RULE1] [RULE6]
	assign clipped = excess[17] ? 17'h00000 : excess[16:0];
	assign aboveFilter = ticks > $signed({6'h00, filterLevel}); // [RULE14]
	assign belowNeg = ticks < -$signed({6'h00, negLevel}); // [RULE12]
endmodule : wtpe_sensor_lane
`default_nettype wire

/* File: logic/wtpe_position_engine.sv */
// Wheel touch, position, rotation and compensation engine.
// Function
// [RULE1] Pressure sums tick excess over touch level, skipping sensors below level.
// [RULE2] Zero pressure means released; pressure above margin means touched.
// [RULE3] Debounce counting starts once pressure exceeds the touch margin.
// [RULE4] Touch uses debounce bits 1:0, release uses bits 3:2.
// [RULE5] Debounce code 00 is immediate; 01..11 mean two to four samples.
// [RULE6] Position is scale/32 times weighted excess sum over pressure.
// [RULE7] The 16-bit scale joins a high byte and a low byte register.
// [RULE8] Position is readable as a high byte and a low byte.
// [RULE9] Position is bounded to zero through scale/32 times sensor count.
// [RULE10] Angle shift adds segments of 1/256 turn clockwise; zero changes nothing.
// [RULE11] Angle shift is an 8-bit register at 0x31, reset zero.
// [RULE12] Count samples below negative level; request recalibration past the limit; code requests it once the count reaches the limit.
// [RULE13] Host should program the negative count limit to one.
// [RULE14] Averaging hold is raised while ticks exceed the filter hold level.
// [RULE15] Three or more sensors above filter level request recalibration.
// [RULE16] Margin and level registers scale by four ticks per code step.
// [RULE17] Rotation flags set only when step between samples exceeds threshold.
// [RULE18] Spin threshold is a percentage of the location limit, default two.
// [RULE19] Stuck timeout forces release; new touch only after real release.
// [RULE20] A zero stuck timeout disables the forced release.
// [RULE21] Stuck timeout counts whole seconds, one to 255.
// [RULE22] Pressure between zero and margin keeps the reported status.
// [RULE23] All decisions are made once per scan sample.
`timescale 1ns/1ps
`default_nettype none
`include "wtpe_cfg.svh"
module wtpe_position_engine #(
	parameter int unsigned STUCK_SECOND_CYCLES =
		`WTPE_SECOND_NS / `WTPE_CLK_PERIOD_NS
) (
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic sampleValid,
	input wire logic [127:0] sensorTicks,
	input wire logic [127:0] sensorTouchLevels,
	input wire logic [7:0] regAddr,
	input wire logic [7:0] regWrData,
	input wire logic regWrEn,
	output logic [7:0] regRdData,
	output logic [15:0] wheelLocation,
	output logic wheelTouched,
	output logic spinClockwise,
	output logic spinCounterClockwise,
	output logic filterHold,
	output logic recalRequest,
	output logic resultValid
);
	logic [7:0] debounceCfg_reg;
	logic [7:0] stuckTimeout_reg;
	logic [7:0] touchMargin_reg;
	logic [7:0] scaleHigh_reg;
	logic [7:0] scaleLow_reg;
	logic [7:0] filterLevel_reg;
	logic [7:0] negLevel_reg;
	logic [7:0] negCountLimit_reg;
	logic [7:0] spinLevel_reg;
	logic [7:0] angleShift_reg;
	wtpe_pkg::wtpe_state_t state_reg;
	wtpe_pkg::wtpe_state_t state_next;
	logic [2:0] debounceCount_reg;
	logic [2:0] debounceCount_next;
	logic [7:0] negCount_reg;
	logic [31:0] secondCycles_reg;
	logic [7:0] seconds_reg;
	logic [15:0] location_reg;
	logic prevTouched_reg;
	logic spinCw_reg;
	logic spinCcw_reg;
	logic filterHold_reg;
	logic recal_reg;
	logic valid_reg;

	wire logic [16:0] clipped [`WTPE_SENSORS];
	wire logic [`WTPE_SENSORS-1:0] aboveFilter;
	wire logic [`WTPE_SENSORS-1:0] belowNeg;
	wire logic [9:0] filterTicks;
	wire logic [9:0] negTicks;
	wire logic [9:0] marginTicks;

	// Level registers count four ticks per code step. [RULE16]
	assign filterTicks = {filterLevel_reg, 2'h0};
	assign negTicks = {negLevel_reg, 2'h0};
	assign marginTicks = {touchMargin_reg, 2'h0};

	genvar gi;
	generate
		for (gi = 0; gi < `WTPE_SENSORS; gi++)
		begin : g_lane
			wtpe_sensor_lane uLane (
				.ticks(sensorTicks[gi*16 +: 16]),
				.touchLevel(sensorTouchLevels[gi*16 +: 16]),
				.filterLevel(filterTicks),
				.negLevel(negTicks),
				.clipped(clipped[gi]),
				.aboveFilter(aboveFilter[gi]),
				.belowNeg(belowNeg[gi])
			);
		end
	endgenerate

	logic [19:0] pressure;
	logic [22:0] weighted;
	logic [3:0] aboveCount;
	always_comb
	begin
		pressure = 20'h00000;
		weighted = 23'h000000;
		aboveCount = 4'h0;
		for (int i = 0; i < `WTPE_SENSORS; i++)
		begin
			pressure = pressure + 20'(clipped[i]); // [RULE1]
			weighted = weighted + 23'(clipped[i]) * 23'(i); // [RULE6]
			aboveCount = aboveCount + 4'(aboveFilter[i]);
		end
	end

	wire logic [15:0] scale;
	wire logic [13:0] locationLimit;
	wire logic [38:0] scaledWeighted;
	wire logic [38:0] quotient;
	wire logic [15:0] rawLocation;
	wire logic [15:0] boundLocation;
	wire logic [21:0] shiftProduct;
	wire logic [16:0] shiftedSum;
	wire logic [15:0] finalLocation;
	assign scale = {scaleHigh_reg, scaleLow_reg}; // [RULE7]
	// Limit is scale/32 times eight sensors. [RULE9]
	assign locationLimit = scale[15:`WTPE_LIMIT_SHIFT];
	assign scaledWeighted = 39'(scale) * 39'(weighted); // [RULE6]
	assign quotient = (pressure == 20'h00000) ? 39'h0 :
		(scaledWeighted / 39'(pressure)) >> `WTPE_SCALE_SHIFT;
	assign rawLocation = quotient[15:0];
	assign boundLocation = (quotient > 39'(locationLimit)) ?
		16'(locationLimit) : rawLocation; // [RULE9]
	// Shift by angle segments of one 256th turn, wrapping. [RULE10]
	assign shiftProduct = 22'(angleShift_reg) * 22'(locationLimit);
	assign shiftedSum = 17'(boundLocation) +
		17'(shiftProduct >> `WTPE_SEGMENT_SHIFT);
	assign finalLocation = (shiftedSum >= 17'(locationLimit) &&
		locationLimit != 14'h0000) ?
		16'(shiftedSum - 17'(locationLimit)) : shiftedSum[15:0];

	wire logic signed [17:0] step;
	wire logic signed [17:0] halfLimit;
	wire logic signed [17:0] wrappedStep;
	wire logic [17:0] stepMag;
	wire logic [21:0] spinProduct;
	wire logic [21:0] spinThreshold;
	assign step = $signed(18'(finalLocation)) - $signed(18'(location_reg));
	assign halfLimit = $signed(18'(locationLimit >> 1));
	assign wrappedStep = (step > halfLimit) ?
		step - $signed(18'(locationLimit)) :
		(step < -halfLimit) ? step + $signed(18'(locationLimit)) : step;
	assign stepMag = wrappedStep[17] ? 18'(-wrappedStep) : 18'(wrappedStep);
	// Threshold is a percentage of the location limit. [RULE18]
	assign spinProduct = 22'(spinLevel_reg) * 22'(locationLimit);
	assign spinThreshold = spinProduct / 22'(`WTPE_PERCENT);
	wire logic spinFast;
	assign spinFast = 22'(stepMag) > spinThreshold; // [RULE17]

	wire logic touchCandidate;
	wire logic releaseCandidate;
	wire logic touchDone;
	wire logic releaseDone;
	wire logic stuckExpired;
	wire logic negHit;
	wire logic [7:0] negCountInc;
	wire logic negTrigger;
	wire logic avgTrigger;
	assign touchCandidate = pressure > 20'(marginTicks); // [RULE2] [RULE3]
	assign releaseCandidate = pressure == 20'h00000; // [RULE2]
	// Code 00 decides on the incoming sample, code n on n+1. [RULE4] [RULE5]
	assign touchDone = debounceCount_reg >= 3'(debounceCfg_reg[1:0]);
	assign releaseDone = debounceCount_reg >= 3'(debounceCfg_reg[3:2]);
	assign stuckExpired = stuckTimeout_reg != 8'h00 &&
		seconds_reg >= stuckTimeout_reg; // [RULE20] [RULE21]
	assign negHit = |belowNeg;
	assign negCountInc = (negCount_reg == 8'hFF) ? negCount_reg :
		negCount_reg + 8'h01;
	// A limit of one recalibrates on the first low sample. [RULE12] [RULE13]
	assign negTrigger = negHit && negCountInc >= negCountLimit_reg;
	assign avgTrigger = aboveCount >= 4'(`WTPE_COMP_MIN_SENSORS); // [RULE15]

	always_comb
	begin
		state_next = state_reg;
		debounceCount_next = debounceCount_reg;
		unique case (state_reg)
			wtpe_pkg::WTPE_RELEASED:
			begin
				if (touchCandidate && touchDone)
				begin
					state_next = wtpe_pkg::WTPE_TOUCHED;
					debounceCount_next = 3'h0;
				end
				else if (touchCandidate)
					debounceCount_next = debounceCount_reg + 3'h1; // [RULE3]
				else
					debounceCount_next = 3'h0;
			end
			wtpe_pkg::WTPE_TOUCHED:
			begin
				if (releaseCandidate && releaseDone)
				begin
					state_next = wtpe_pkg::WTPE_RELEASED;
					debounceCount_next = 3'h0;
				end
				else if (releaseCandidate)
					debounceCount_next = debounceCount_reg + 3'h1; // [RULE4]
				else
					debounceCount_next = 3'h0; // [RULE22]
			end
			wtpe_pkg::WTPE_STUCK:
			begin
				debounceCount_next = 3'h0;
				if (releaseCandidate)
					state_next = wtpe_pkg::WTPE_RELEASED; // [RULE19]
			end
			default:
			begin
				state_next = wtpe_pkg::WTPE_RELEASED;
				debounceCount_next = 3'h0;
			end
		endcase
	end

	wire logic nowTouched;
	assign nowTouched = state_next == wtpe_pkg::WTPE_TOUCHED;

	always_ff @(posedge clk_sys)
	begin
		if (reset)
		begin
			debounceCfg_reg <= `WTPE_RST_DEBOUNCE; // [RULE5]
			stuckTimeout_reg <= `WTPE_RST_STUCK;
			touchMargin_reg <= `WTPE_RST_MARGIN;
			scaleHigh_reg <= `WTPE_RST_SCALE_HI;
			scaleLow_reg <= `WTPE_RST_SCALE_LO;
			filterLevel_reg <= `WTPE_RST_FILTER;
			negLevel_reg <= `WTPE_RST_NEG;
			negCountLimit_reg <= `WTPE_RST_NEG_CNT;
			spinLevel_reg <= `WTPE_RST_SPIN;
			angleShift_reg <= `WTPE_RST_ANGLE; // [RULE11]
		end
		else if (regWrEn)
		begin
			if (regAddr == `WTPE_ADDR_DEBOUNCE)
				debounceCfg_reg <= {4'h0, regWrData[3:0]};
			if (regAddr == `WTPE_ADDR_STUCK)
				stuckTimeout_reg <= regWrData;
			if (regAddr == `WTPE_ADDR_MARGIN)
				touchMargin_reg <= regWrData;
			if (regAddr == `WTPE_ADDR_SCALE_HI)
				scaleHigh_reg <= regWrData;
			if (regAddr == `WTPE_ADDR_SCALE_LO)
				scaleLow_reg <= regWrData;
			if (regAddr == `WTPE_ADDR_FILTER)
				filterLevel_reg <= regWrData;
			if (regAddr == `WTPE_ADDR_NEG)
				negLevel_reg <= regWrData;
			if (regAddr == `WTPE_ADDR_NEG_CNT)
				negCountLimit_reg <= regWrData;
			if (regAddr == `WTPE_ADDR_SPIN)
				spinLevel_reg <= regWrData;
			if (regAddr == `WTPE_ADDR_ANGLE)
				angleShift_reg <= regWrData; // [RULE11]
		end
	end

	// Stuck timer counts whole seconds of continuous touch. [RULE21]
	always_ff @(posedge clk_sys)
	begin
		if (reset || state_reg != wtpe_pkg::WTPE_TOUCHED)
		begin
			secondCycles_reg <= 32'h00000000;
			seconds_reg <= 8'h00;
		end
		else if (secondCycles_reg >= STUCK_SECOND_CYCLES - 1)
		begin
			secondCycles_reg <= 32'h00000000;
			if (seconds_reg != 8'hFF)
				seconds_reg <= seconds_reg + 8'h01;
		end
		else
			secondCycles_reg <= secondCycles_reg + 32'h00000001;
	end

	// Decisions update only on a scan sample. [RULE23]
	always_ff @(posedge clk_sys)
	begin
		if (reset)
		begin
			state_reg <= wtpe_pkg::WTPE_RELEASED;
			debounceCount_reg <= 3'h0;
			negCount_reg <= 8'h00;
			location_reg <= 16'h0000;
			prevTouched_reg <= 1'b0;
			spinCw_reg <= 1'b0;
			spinCcw_reg <= 1'b0;
			filterHold_reg <= 1'b0;
			recal_reg <= 1'b0;
			valid_reg <= 1'b0;
		end
		else if (sampleValid)
		begin
			if (state_reg == wtpe_pkg::WTPE_TOUCHED && stuckExpired)
			begin
				state_reg <= wtpe_pkg::WTPE_STUCK; // [RULE19] [RULE20]
				debounceCount_reg <= 3'h0;
			end
			else
			begin
				state_reg <= state_next; // [RULE2] [RULE22]
				debounceCount_reg <= debounceCount_next;
			end
			if (pressure != 20'h00000)
				location_reg <= finalLocation; // [RULE6] [RULE10]
			prevTouched_reg <= nowTouched;
			spinCw_reg <= nowTouched && prevTouched_reg && spinFast &&
				!wrappedStep[17]; // [RULE17]
			spinCcw_reg <= nowTouched && prevTouched_reg && spinFast &&
				wrappedStep[17]; // [RULE17]
			filterHold_reg <= |aboveFilter; // [RULE14]
			negCount_reg <= (!negHit || negTrigger) ? 8'h00 : negCountInc;
			recal_reg <= negTrigger || avgTrigger; // [RULE12] [RULE15]
			valid_reg <= 1'b1;
		end
		else
		begin
			recal_reg <= 1'b0;
			valid_reg <= 1'b0;
		end
	end

	wire logic [7:0] statusByte;
	assign statusByte = {4'h0, filterHold_reg, spinCcw_reg, spinCw_reg,
		state_reg == wtpe_pkg::WTPE_TOUCHED};
	// Position bytes are readable by the host. [RULE8]
	assign regRdData =
		(regAddr == `WTPE_ADDR_DEBOUNCE) ? debounceCfg_reg :
		(regAddr == `WTPE_ADDR_STUCK) ? stuckTimeout_reg :
		(regAddr == `WTPE_ADDR_MARGIN) ? touchMargin_reg :
		(regAddr == `WTPE_ADDR_SCALE_HI) ? scaleHigh_reg :
		(regAddr == `WTPE_ADDR_SCALE_LO) ? scaleLow_reg :
		(regAddr == `WTPE_ADDR_FILTER) ? filterLevel_reg :
		(regAddr == `WTPE_ADDR_NEG) ? negLevel_reg :
		(regAddr == `WTPE_ADDR_NEG_CNT) ? negCountLimit_reg :
		(regAddr == `WTPE_ADDR_SPIN) ? spinLevel_reg :
		(regAddr == `WTPE_ADDR_ANGLE) ? angleShift_reg :
		(regAddr == `WTPE_ADDR_LOC_HI) ? location_reg[15:8] :
		(regAddr == `WTPE_ADDR_LOC_LO) ? location_reg[7:0] :
		(regAddr == `WTPE_ADDR_STATUS) ? statusByte : 8'h00;

	assign wheelLocation = location_reg;
	assign wheelTouched = state_reg == wtpe_pkg::WTPE_TOUCHED;
	assign spinClockwise = spinCw_reg;
	assign spinCounterClockwise = spinCcw_reg;
	assign filterHold = filterHold_reg;
	assign recalRequest = recal_reg;
	assign resultValid = valid_reg;
endmodule : wtpe_position_engine
`default_nettype wire

/* File: tb/wtpe_position_engine_assertions.sv */
// Port checks for the wheel touch position engine.
`timescale 1ns/1ps
`default_nettype none
module wtpe_assertions #(
	parameter int unsigned STUCK_SECOND_CYCLES = 20
) (
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic sampleValid,
	input wire logic [7:0] regAddr,
	input wire logic [7:0] regWrData,
	input wire logic regWrEn,
	input wire logic [7:0] regRdData,
	input wire logic [15:0] wheelLocation,
	input wire logic wheelTouched,
	input wire logic spinClockwise,
	input wire logic spinCounterClockwise,
	input wire logic recalRequest,
	input wire logic resultValid
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (reset);
	sequence s_angle_write;
		regWrEn && regAddr == 8'h31;
	endsequence
	sequence s_angle_read;
		regAddr == 8'h31 && !regWrEn;
	endsequence
	property p_result_pulse;
		sampleValid |=> resultValid;
	endproperty
	a_result_pulse: assert property (p_result_pulse)
		else $error("result strobe missing after sample");
	property p_result_only;
		!sampleValid |=> !resultValid;
	endproperty
	a_result_only: assert property (p_result_only)
		else $error("result strobe without sample");
	property p_recal_timing;
		recalRequest |-> resultValid && $past(sampleValid);
	endproperty
	a_recal_timing: assert property (p_recal_timing)
		else $error("recalibration pulse out of step");
	property p_touch_hold;
		$changed(wheelTouched) |-> resultValid;
	endproperty
	a_touch_hold: assert property (p_touch_hold)
		else $error("touch status moved between samples");
	property p_location_hold;
		$changed(wheelLocation) |-> resultValid;
	endproperty
	a_location_hold: assert property (p_location_hold)
		else $error("location moved between samples");
	property p_spin_excl;
		!(spinClockwise && spinCounterClockwise);
	endproperty
	a_spin_excl: assert property (p_spin_excl)
		else $error("both rotation flags set");
	property p_spin_timing;
		$changed(spinClockwise) || $changed(spinCounterClockwise)
			|-> resultValid;
	endproperty
	a_spin_timing: assert property (p_spin_timing)
		else $error("rotation flag moved between samples");
	property p_angle_store;
		s_angle_write ##1 s_angle_read |-> regRdData == $past(regWrData);
	endproperty
	a_angle_store: assert property (p_angle_store)
		else $error("angle shift register lost its write");
	property p_reset_clear;
		$fell(reset) |-> wheelLocation == 16'h0000 && !wheelTouched;
	endproperty
	a_reset_clear: assert property (p_reset_clear)
		else $error("outputs not cleared by reset");
endmodule : wtpe_assertions
bind wtpe_position_engine wtpe_assertions #(
	.STUCK_SECOND_CYCLES(STUCK_SECOND_CYCLES)
) wtpe_assertions_i (.clk_sys, .reset, .sampleValid, .regAddr, .regWrData,
	.regWrEn, .regRdData, .wheelLocation, .wheelTouched, .spinClockwise,
	.spinCounterClockwise, .recalRequest, .resultValid);
`default_nettype wire

/* File: tb/wtpe_host_model.sv */
// Host model that drives the byte register port.
`timescale 1ns/1ps
`default_nettype none
module wtpe_host_model (
	input wire logic clk_sys,
	output logic [7:0] regAddr,
	output logic [7:0] regWrData,
	output logic regWrEn,
	input wire logic [7:0] regRdData
);
	initial
	begin
		regAddr = 8'h00;
		regWrData = 8'h00;
		regWrEn = 1'b0;
	end
	task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_sys) #1;
		regAddr = a;
		regWrData = d;
		regWrEn = 1'b1;
		@(posedge clk_sys) #1;
		regWrEn = 1'b0;
		regWrData = ~d;
	endtask : write_reg
	task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk_sys) #1;
		regAddr = a;
		@(negedge clk_sys);
		d = regRdData;
	endtask : read_reg
	task automatic program_defaults;
		write_reg(8'h2F, 8'h01);
	endtask : program_defaults
endmodule : wtpe_host_model
`default_nettype wire

/* File: tb/tb.sv */
// Self-checking bench for the wheel touch position engine.
`timescale 1ns/1ps
`default_nettype none
module tb;
	typedef struct {
		logic [127:0] tk;
		logic [127:0] lv;
		logic [15:0] loc;
		logic tch;
	} wtpe_row_t;
	logic clk_sys = 1'b0;
	logic reset = 1'b1;
	logic sampleValid = 1'b0;
	logic [127:0] sensorTicks = '0;
	logic [127:0] sensorTouchLevels = '0;
	logic [7:0] regAddr, regWrData, regRdData, rd;
	logic regWrEn, wheelTouched, spinClockwise, spinCounterClockwise;
	logic filterHold, recalRequest, resultValid;
	logic [15:0] wheelLocation;
	int num_errors = 0;
	int num_checks = 0;
	wtpe_row_t rows [9];
	logic [7:0] ra [11] = '{8'h27, 8'h28, 8'h29, 8'h2B, 8'h2C, 8'h2D,
		8'h2E, 8'h2F, 8'h30, 8'h31, 8'h2A};
	logic [7:0] rv [11] = '{8'h00, 8'h00, 8'h03, 8'h01, 8'h00, 8'h50,
		8'h50, 8'h01, 8'h02, 8'h00, 8'h00};
	always #2 clk_sys = ~clk_sys;
	wtpe_position_engine #(.STUCK_SECOND_CYCLES(20)) wtpe_position_engine_i (
		.clk_sys, .reset, .sampleValid, .sensorTicks, .sensorTouchLevels,
		.regAddr, .regWrData, .regWrEn, .regRdData, .wheelLocation,
		.wheelTouched, .spinClockwise, .spinCounterClockwise, .filterHold,
		.recalRequest, .resultValid);
	wtpe_host_model wtpe_host_model_i (.clk_sys, .regAddr, .regWrData,
		.regWrEn, .regRdData);
	function automatic logic [127:0] t(input int i, input logic [15:0] v);
		t = '0;
		t[16*i +: 16] = v;
	endfunction : t
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		num_checks++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic sample(input logic [127:0] tk, input logic [127:0] lv);
		@(posedge clk_sys) #1;
		sensorTicks = tk;
		sensorTouchLevels = lv;
		sampleValid = 1'b1;
		@(posedge clk_sys) #1;
		sampleValid = 1'b0;
		check(resultValid, 1'b1);
	endtask : sample
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		wtpe_host_model_i.write_reg(a, d);
	endtask : wr
	task automatic rdc(input logic [7:0] a, input logic [7:0] e);
		wtpe_host_model_i.read_reg(a, rd);
		check(rd, e);
	endtask : rdc
	task automatic complete_run;
		if (num_errors == 0 && num_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : complete_run
	initial
	begin
		rows[0] = '{t(1, 16'h0064), '0, 16'h0008, 1'b1};
		rows[1] = '{t(7, 16'h0064), '0, 16'h0038, 1'b1};
		rows[2] = '{t(0, 16'h0032) | t(1, 16'h0032), '0, 16'h0004, 1'b1};
		rows[3] = '{t(6, 16'h0032) | t(7, 16'h0032), '0, 16'h0034, 1'b1};
		rows[4] = '{t(1, 16'h0064) | t(2, 16'h0064), t(2, 16'h00C8),
			16'h0008, 1'b1};
		rows[5] = '{'0, '0, 16'h0008, 1'b0};
		rows[6] = '{t(1, 16'h000A), '0, 16'h0008, 1'b0};
		rows[7] = '{t(1, 16'h000D), '0, 16'h0008, 1'b1};
		rows[8] = '{t(1, 16'h000A), '0, 16'h0008, 1'b1};
		repeat (5) @(posedge clk_sys);
		#1 reset = 1'b0;
		check(wheelLocation, 16'h0000);
		foreach (ra[k])
			rdc(ra[k], rv[k]);
		wtpe_host_model_i.program_defaults();
		foreach (rows[k])
		begin
			sample(rows[k].tk, rows[k].lv);
			check(wheelLocation, rows[k].loc);
			check(wheelTouched, rows[k].tch);
		end
		sample(t(1, 16'h0032) | t(2, 16'h0032), '0);
		check({spinClockwise, spinCounterClockwise}, 2'b10);
		sample(t(1, 16'h0032) | t(2, 16'h0032), '0);
		check({spinClockwise, spinCounterClockwise}, 2'b00);
		sample(t(1, 16'h0064), '0);
		check({spinClockwise, spinCounterClockwise}, 2'b01);
		rdc(8'h22, 8'h05);
		wr(8'h31, 8'h40);
		sample(t(1, 16'h0064), '0);
		check(wheelLocation, 16'h0018);
		rdc(8'h20, 8'h00);
		rdc(8'h21, 8'h18);
		wr(8'h20, 8'hFF);
		rdc(8'h20, 8'h00);
		wr(8'h31, 8'hC0);
		sample(t(7, 16'h0064), '0);
		check(wheelLocation, 16'h0028);
		wr(8'h31, 8'h00);
		wr(8'h27, 8'hFF);
		rdc(8'h27, 8'h0F);
		wr(8'h27, 8'h05);
		sample('0, '0);
		check(wheelTouched, 1'b1);
		sample('0, '0);
		check(wheelTouched, 1'b0);
		sample(t(1, 16'h0064), '0);
		check(wheelTouched, 1'b0);
		sample(t(1, 16'h0064), '0);
		check(wheelTouched, 1'b1);
		wr(8'h27, 8'h00);
		sample(t(0, 16'hFE70), '0);
		check(recalRequest, 1'b1);
		sample(t(0, 16'hFEC0), '0);
		check(recalRequest, 1'b0);
		sample(t(0, 16'h0190) | t(1, 16'h0190) | t(2, 16'h0190), '0);
		check({recalRequest, filterHold}, 2'b11);
		sample(t(0, 16'h0190) | t(1, 16'h0190), '0);
		check({recalRequest, filterHold}, 2'b01);
		sample('0, '0);
		wr(8'h28, 8'h01);
		sample(t(1, 16'h0064), '0);
		check(wheelTouched, 1'b1);
		repeat (30) @(posedge clk_sys);
		sample(t(1, 16'h0064), '0);
		check(wheelTouched, 1'b0);
		sample(t(1, 16'h0064), '0);
		check(wheelTouched, 1'b0);
		sample('0, '0);
		sample(t(1, 16'h0064), '0);
		check(wheelTouched, 1'b1);
		wr(8'h28, 8'h00);
		repeat (30) @(posedge clk_sys);
		sample(t(1, 16'h0064), '0);
		check(wheelTouched, 1'b1);
		complete_run();
	end
endmodule : tb
`default_nettype wire
